// *** hw/rwa_top.v ***
// Purpose: Main window and overlay fetch addressing under four rotations.
// Assumes: Scan strobes come from panel timing, synchronous to clock.
// Notes: Start addresses are computed by software for each rotation.
//
// How it works
// - Settings bit 19 enables the overlay window inside the main window.
// - Overlay uses the main window's color depth and rotation.
// - Overlay may sit anywhere in the virtual area, not only visible.
// - Overlay location comes from X positions 58h and Y positions 5Ch.
// - Overlay fetches from its own start 50h and line offset 54h.
// - Overlay start is 17 dword bits: bits 15-0 plus bit 16.
// - Start zero is the first buffer location; steps are 32-bit dwords.
// - Virtual width in pixels is line offset times 32 over bpp.
// - Main line offset is ten bits giving dwords per line.
// - Overlay positions hold ten-bit end and start bounds.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "rwa_consts.vh"

module rwa_top (
	input wire clock, // System clock, 125 MHz.
	input wire rstn, // Asynchronous reset, active low.
	input wire ce, // Clock enable, freezes all state but the reset release while low.
	input wire [`RWA_AW-1:0] reg_addr, // Register byte address.
	input wire [31:0] reg_wdata, // Register write data.
	input wire reg_wr, // Write strobe, one cycle.
	input wire reg_rd, // Read strobe, one cycle.
	output reg [31:0] reg_rdata, // Read data, valid the cycle after.
	input wire frame_start, // Pulse at the first line of a frame.
	input wire line_start, // Pulse at the start of every later line.
	input wire fetch, // Pulse requesting the next dword.
	input wire [`RWA_POS_HI:0] scan_x, // Scan column in position units.
	input wire [`RWA_POS_HI:0] scan_y, // Scan line number.
	output reg [`RWA_ADDR_HI:0] fetch_addr, // Dword address of the fetch.
	output reg fetch_ovl, // Fetch comes from the overlay image.
	output reg fetch_valid, // Pulse: fetch_addr is new.
	output reg [14:0] virt_width, // Virtual main image width, pixels.
	output reg [1:0] rotation, // Current rotation setting.
	output reg [4:0] bpp_sel // Current color depth.
);

	// ****************************************
	// Reset release
	// ****************************************
	reg rst_s1_ff;
	reg rst_s2_ff;

	// The release is synchronous, so no flop sees reset leave in mid-setup.
	// Two flops so reset leaves every register on the same edge.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	wire rst_n;
	assign rst_n = rst_s2_ff;

	// ****************************************
	// Register file
	// ****************************************
	reg [31:0] settings_ff;
	reg [`RWA_ADDR_HI:0] main_start_ff;
	reg [`RWA_LOFS_HI:0] main_lofs_ff;
	reg [`RWA_ADDR_HI:0] ovl_start_ff;
	reg [`RWA_LOFS_HI:0] ovl_lofs_ff;
	reg [31:0] ovl_xpos_ff;
	reg [31:0] ovl_ypos_ff;
	wire [31:0] pos_mask;

	// Only the two ten-bit bounds of a position register are stored.
	assign pos_mask = {6'h00, {10{1'b1}}, 6'h00, {10{1'b1}}};

	// Writes take effect at once; a frame already under way sees new offsets and settings,
	// but new start addresses are loaded only at the next frame start.
	// Register writes; unmapped writes are dropped.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			settings_ff <= `RWA_ZERO32;
			main_start_ff <= {`RWA_ADDR_W{1'b0}};
			main_lofs_ff <= 10'h000;
			ovl_start_ff <= {`RWA_ADDR_W{1'b0}};
			ovl_lofs_ff <= 10'h000;
			ovl_xpos_ff <= `RWA_ZERO32;
			ovl_ypos_ff <= `RWA_ZERO32;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				`RWA_OFS_SETTINGS: begin
					settings_ff <= reg_wdata & `RWA_SET_MASK;
				end
				`RWA_OFS_MAIN_START: begin
					main_start_ff <= reg_wdata[`RWA_ADDR_HI:0];
				end
				`RWA_OFS_MAIN_LOFS: begin
					main_lofs_ff <= reg_wdata[`RWA_LOFS_HI:0];
				end
				`RWA_OFS_OVL_START: begin
					ovl_start_ff <= reg_wdata[`RWA_ADDR_HI:0];
				end
				`RWA_OFS_OVL_LOFS: begin
					ovl_lofs_ff <= reg_wdata[`RWA_LOFS_HI:0];
				end
				`RWA_OFS_OVL_XPOS: begin
					ovl_xpos_ff <= reg_wdata & pos_mask;
				end
				`RWA_OFS_OVL_YPOS: begin
					ovl_ypos_ff <= reg_wdata & pos_mask;
				end
				default: begin
					settings_ff <= settings_ff;
				end
			endcase
		end
	end

	// ****************************************
	// Settings decode
	// ****************************************
	wire ovl_en;
	wire [1:0] rot;
	wire [4:0] bpp;

	// The overlay has no depth or rotation field; it reads the main ones.
	// overlay enable bit
	assign ovl_en = settings_ff[`RWA_BIT_OVL_EN];
	assign rot = settings_ff[`RWA_ROT_HI:`RWA_ROT_LO];
	assign bpp = settings_ff[`RWA_BPP_HI:`RWA_BPP_LO];

	// An illegal depth yields a virtual width equal to the raw offset, which
	// keeps the width output defined rather than guessing a depth.
	// Pixels per dword as a shift; unknown depths give a shift of zero.
	reg [3:0] px_shift;
	always @* begin
		case (bpp)
			`RWA_BPP_1: px_shift = `RWA_SH_1;
			`RWA_BPP_2: px_shift = `RWA_SH_2;
			`RWA_BPP_4: px_shift = `RWA_SH_4;
			`RWA_BPP_8: px_shift = `RWA_SH_8;
			`RWA_BPP_16: px_shift = `RWA_SH_16;
			default: px_shift = `RWA_SH_NONE;
		endcase
	end

	// Direction of the walk for each rotation. Pixels run backwards at
	// 90 and 180 because the start points at the end of a padded line;
	// lines run backwards at 180 and 270 because the start is the last line.
	reg dec_pix;
	reg dec_line;
	always @* begin
		case (rot)
			`RWA_ROT_0: begin
				dec_pix = 1'b0;
				dec_line = 1'b0;
			end
			`RWA_ROT_90: begin
				dec_pix = 1'b1;
				dec_line = 1'b0;
			end
			`RWA_ROT_180: begin
				dec_pix = 1'b1;
				dec_line = 1'b1;
			end
			`RWA_ROT_270: begin
				dec_pix = 1'b0;
				dec_line = 1'b1;
			end
			default: begin
				dec_pix = 1'b0;
				dec_line = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Overlay window hit
	// ****************************************
	wire win_hit;
	wire ovl_hit;

	rwa_win_hit u_hit (
		.rot(rot),
		.scan_x(scan_x),
		.scan_y(scan_y),
		.xpos(ovl_xpos_ff),
		.ypos(ovl_ypos_ff),
		.hit(win_hit)
	);

	assign ovl_hit = ovl_en && win_hit;

	// The overlay advances a line only after a line that touched it,
	// so rows above the overlay do not consume overlay lines.
	reg ovl_row_ff;
	wire nxt_ovl_row;
	assign nxt_ovl_row = line_start ? 1'b0 : (ovl_row_ff | (fetch & ovl_hit));

	// ****************************************
	// Address walkers, main then overlay
	// ****************************************
	wire [`RWA_ADDR_HI:0] walk_addr [0:1];
	wire [`RWA_ADDR_HI:0] walk_start [0:1];
	wire [`RWA_LOFS_HI:0] walk_off [0:1];
	wire [1:0] walk_line;
	wire [1:0] walk_step;

	assign walk_start[0] = main_start_ff;
	assign walk_start[1] = ovl_start_ff;
	assign walk_off[0] = main_lofs_ff;
	assign walk_off[1] = ovl_lofs_ff;
	// Index zero is the main window and index one the overlay; both share
	// the rotation directions, as the overlay has no rotation of its own.
	// Main steps on every fetch so it stays aligned under the overlay.
	assign walk_line[0] = line_start;
	assign walk_line[1] = line_start & ovl_row_ff;
	assign walk_step[0] = fetch;
	assign walk_step[1] = fetch & ovl_hit;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_walk
			rwa_addr_walk u_walk (
				.clock(clock),
				.rst_n(rst_n),
				.ce(ce),
				.load(frame_start),
				.line_adv(walk_line[gi]),
				.step(walk_step[gi]),
				.dec_pix(dec_pix),
				.dec_line(dec_line),
				.start_addr(walk_start[gi]),
				.line_off(walk_off[gi]),
				.addr(walk_addr[gi])
			);
		end
	endgenerate

	// ****************************************
	// Fetch output and line count
	// ****************************************
	reg [`RWA_POS_HI:0] line_cnt_ff;

	// A fetch on a frame or line strobe is refused: the walkers are
	// reloading in that cycle and would hand out a stale address.
	// The address presented is the one before the walker steps past it.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetch_addr <= {`RWA_ADDR_W{1'b0}};
			fetch_ovl <= 1'b0;
			fetch_valid <= 1'b0;
			ovl_row_ff <= 1'b0;
			line_cnt_ff <= 10'h000;
		end else if (ce) begin
			fetch_valid <= fetch & ~frame_start & ~line_start;
			ovl_row_ff <= frame_start ? 1'b0 : nxt_ovl_row;
			if (fetch && !frame_start && !line_start) begin
				fetch_addr <= ovl_hit ? walk_addr[1] : walk_addr[0];
				fetch_ovl <= ovl_hit;
			end
			if (frame_start) begin
				line_cnt_ff <= 10'h000;
			end else if (line_start) begin
				line_cnt_ff <= line_cnt_ff + `RWA_ONE10;
			end
		end
	end

	// ****************************************
	// Virtual width and settings mirror
	// ****************************************
	// Width is in pixels of the padded virtual line, not the visible panel.
	// offset times pixels per dword
	// padded width at 0 and 180
	// padded width at 90 and 270
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			virt_width <= 15'h0000;
			rotation <= `RWA_ROT_0;
			bpp_sel <= 5'h00;
		end else if (ce) begin
			virt_width <= {5'h00, main_lofs_ff} << px_shift;
			rotation <= rot;
			bpp_sel <= bpp;
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	// The status word is for bring-up; its line count wraps after 1023 lines.
	// Unmapped addresses and n/a bits read as zero; data stand one cycle.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `RWA_ZERO32;
		end else if (ce) begin
			reg_rdata <= `RWA_ZERO32;
			if (reg_rd) begin
				case (reg_addr)
					`RWA_OFS_SETTINGS: reg_rdata <= settings_ff;
					`RWA_OFS_MAIN_START: reg_rdata <= {15'h0000, main_start_ff};
					`RWA_OFS_MAIN_LOFS: reg_rdata <= {22'h000000, main_lofs_ff};
					`RWA_OFS_OVL_START: reg_rdata <= {15'h0000, ovl_start_ff};
					`RWA_OFS_OVL_LOFS: reg_rdata <= {22'h000000, ovl_lofs_ff};
					`RWA_OFS_OVL_XPOS: reg_rdata <= ovl_xpos_ff;
					`RWA_OFS_OVL_YPOS: reg_rdata <= ovl_ypos_ff;
					`RWA_OFS_STATUS: begin
						reg_rdata[0] <= fetch_ovl;
						reg_rdata[1] <= ovl_hit;
						reg_rdata[`RWA_STAT_LINE_HI:`RWA_STAT_LINE_LO] <= line_cnt_ff;
					end
					default: reg_rdata <= `RWA_ZERO32;
				endcase
			end
		end
	end

endmodule

// *** common/rwa_consts.vh ***
// Purpose: Shared constants of the rotated window addressing block.
// Assumes: Included by bare name from every design file.
// Notes: Definitions only, no logic.
`ifndef RWA_CONSTS_VH
`define RWA_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define RWA_AW 8
`define RWA_OFS_SETTINGS 8'h10
`define RWA_OFS_MAIN_START 8'h40
`define RWA_OFS_MAIN_LOFS 8'h44
`define RWA_OFS_OVL_START 8'h50
`define RWA_OFS_OVL_LOFS 8'h54
`define RWA_OFS_OVL_XPOS 8'h58
`define RWA_OFS_OVL_YPOS 8'h5C
`define RWA_OFS_STATUS 8'h60
`define RWA_ZERO32 32'h00000000

// ****************************************
// Field layout
// ****************************************
`define RWA_SET_MASK 32'h03DB001F
`define RWA_BIT_OVL_EN 19
`define RWA_ROT_HI 17
`define RWA_ROT_LO 16
`define RWA_BPP_HI 4
`define RWA_BPP_LO 0
`define RWA_ADDR_W 17
`define RWA_ADDR_HI 16
`define RWA_LOFS_HI 9
`define RWA_POS_HI 9
`define RWA_END_HI 25
`define RWA_END_LO 16
`define RWA_STAT_LINE_HI 25
`define RWA_STAT_LINE_LO 16
`define RWA_ONE17 17'h00001
`define RWA_ONE10 10'h001

// ****************************************
// Encodings
// ****************************************
`define RWA_ROT_0 2'h0
`define RWA_ROT_90 2'h1
`define RWA_ROT_180 2'h2
`define RWA_ROT_270 2'h3
`define RWA_BPP_1 5'h01
`define RWA_BPP_2 5'h02
`define RWA_BPP_4 5'h04
`define RWA_BPP_8 5'h08
`define RWA_BPP_16 5'h10
`define RWA_SH_1 4'h5
`define RWA_SH_2 4'h4
`define RWA_SH_4 4'h3
`define RWA_SH_8 4'h2
`define RWA_SH_16 4'h1
`define RWA_SH_NONE 4'h0

`endif

// *** hw/rwa_addr_walk.v ***
// Purpose: Walks the dword fetch addresses of one window image.
// Assumes: Address zero is the first dword of the display buffer.
// Notes: Load wins over a line advance, which wins over a pixel step.
`timescale 1ns/1ps
`include "rwa_consts.vh"

module rwa_addr_walk (
	input wire clock, // System clock.
	input wire rst_n, // Synchronised reset, active low.
	input wire ce, // Clock enable, freezes state when low.
	input wire load, // Frame start, restart at the start address.
	input wire line_adv, // Move to the next image line.
	input wire step, // Move to the next dword of the line.
	input wire dec_pix, // Dwords of a line run downward.
	input wire dec_line, // Lines run downward in memory.
	input wire [`RWA_ADDR_HI:0] start_addr, // Start dword address.
	input wire [`RWA_LOFS_HI:0] line_off, // Dwords per image line.
	output wire [`RWA_ADDR_HI:0] addr // Current dword address.
);

	reg [`RWA_ADDR_HI:0] base_ff;
	reg [`RWA_ADDR_HI:0] addr_ff;
	reg [`RWA_ADDR_HI:0] nxt_base;
	reg [`RWA_ADDR_HI:0] nxt_addr;
	wire [`RWA_ADDR_HI:0] off_ext;

	assign off_ext = {{(`RWA_ADDR_W - 10){1'b0}}, line_off};
	assign addr = addr_ff;

	// Next line base and pixel address; wraps modulo the buffer size.
	always @* begin
		nxt_base = base_ff;
		nxt_addr = addr_ff;
		if (load) begin
			nxt_base = start_addr;
			nxt_addr = start_addr;
		end else if (line_adv) begin
			nxt_base = dec_line ? base_ff - off_ext : base_ff + off_ext;
			nxt_addr = nxt_base;
		end else if (step) begin
			nxt_addr = dec_pix ? addr_ff - `RWA_ONE17 : addr_ff + `RWA_ONE17;
		end
	end

	// State registers.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			base_ff <= {`RWA_ADDR_W{1'b0}};
			addr_ff <= {`RWA_ADDR_W{1'b0}};
		end else if (ce) begin
			base_ff <= nxt_base;
			addr_ff <= nxt_addr;
		end
	end

endmodule

// *** hw/rwa_win_hit.v ***
// Purpose: Decides whether the scan position lies inside the overlay.
// Assumes: Scan x is in position units for the current rotation.
// Notes: Combinational; the caller registers the result.
`timescale 1ns/1ps
`include "rwa_consts.vh"

module rwa_win_hit (
	input wire [1:0] rot, // Shared rotation setting.
	input wire [`RWA_POS_HI:0] scan_x, // Horizontal scan position.
	input wire [`RWA_POS_HI:0] scan_y, // Vertical scan position.
	input wire [31:0] xpos, // Overlay X positions register.
	input wire [31:0] ypos, // Overlay Y positions register.
	output wire hit // Scan lies inside the overlay bounds.
);

	wire swap;
	wire [`RWA_POS_HI:0] cx;
	wire [`RWA_POS_HI:0] cy;

	// rotation shared
	// At 90 and 270 the X register bounds the vertical axis instead.
	assign swap = (rot == `RWA_ROT_90) || (rot == `RWA_ROT_270);
	assign cx = swap ? scan_y : scan_x;
	assign cy = swap ? scan_x : scan_y;

	assign hit = (cx >= xpos[`RWA_POS_HI:0]) && (cx <= xpos[`RWA_END_HI:`RWA_END_LO]) &&
		(cy >= ypos[`RWA_POS_HI:0]) && (cy <= ypos[`RWA_END_HI:`RWA_END_LO]);

endmodule

// *** verification/rwa_chk.sv ***
// Purpose: Port checks for the window addressing top.
// Assumes: Strobes are one cycle long; ce may drop between transfers.
// Notes: Settings are shadowed here to judge reads and fetch sources.
`timescale 1ns/1ps

// ********
// Checker
// ********
module rwa_chk (
	input wire clock, // Clock.
	input wire rstn, // Reset, active low.
	input wire ce, // Clock enable.
	input wire [7:0] reg_addr, // Address.
	input wire [31:0] reg_wdata, // Write data.
	input wire reg_wr, // Write strobe.
	input wire reg_rd, // Read strobe.
	input wire [31:0] reg_rdata, // Read data.
	input wire frame_start, // Frame pulse.
	input wire line_start, // Line pulse.
	input wire fetch, // Fetch pulse.
	input wire [16:0] fetch_addr, // Fetch address.
	input wire fetch_ovl, // Overlay source.
	input wire fetch_valid, // Fetch done.
	input wire [1:0] rotation, // Rotation.
	input wire [4:0] bpp_sel // Color depth.
);
	reg [31:0] set_ff; // Settings shadow.
	wire rd_ok; // Read taken.

	// A taken read needs both the strobe and the enable.
	assign rd_ok = ce && reg_rd;

	// Shadow masked like the register, so a read compares whole.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			set_ff <= 32'h00000000;
		end else if (ce && reg_wr && reg_addr == 8'h10) begin
			set_ff <= reg_wdata & 32'h03DB001F;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	set_read_a: assert property (rd_ok && reg_addr == 8'h10 |=> reg_rdata == set_ff)
		else $error("settings read differs");
	depth_rot_a: assert property (!$past(reg_wr) && !$past(reg_wr, 2) |->
		rotation == set_ff[17:16] && bpp_sel == set_ff[4:0]) else $error("depth or rotation stale");
	ovl_gate_a: assert property (fetch_valid && fetch_ovl |-> $past(set_ff[19]))
		else $error("overlay fetch while disabled");
	fetch_cause_a: assert property (fetch_valid ==
		$past(ce && fetch && !frame_start && !line_start)) else $error("fetch pulse wrong");
	addr_hold_a: assert property (!fetch_valid |-> $stable(fetch_addr) && $stable(fetch_ovl))
		else $error("fetch address moved");
	start_mask_a: assert property (rd_ok && (reg_addr == 8'h40 || reg_addr == 8'h50) |=>
		reg_rdata[31:17] == 15'h0000) else $error("start address too wide");
	lofs_mask_a: assert property (rd_ok && (reg_addr == 8'h44 || reg_addr == 8'h54) |=>
		reg_rdata[31:10] == 22'h000000) else $error("line offset too wide");
	pos_mask_a: assert property (rd_ok && (reg_addr == 8'h58 || reg_addr == 8'h5C) |=>
		(reg_rdata & 32'hFC00FC00) == 32'h00000000) else $error("position field too wide");

	cov_ovl_c: cover property (fetch_valid && fetch_ovl);
	cov_rot_c: cover property (fetch_valid && !fetch_ovl && rotation == 2'h2);
	cov_set_c: cover property (rd_ok && reg_addr == 8'h10);
endmodule

bind rwa_top rwa_chk rwa_chk_inst (.clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.frame_start(frame_start), .line_start(line_start), .fetch(fetch),
	.fetch_addr(fetch_addr), .fetch_ovl(fetch_ovl), .fetch_valid(fetch_valid),
	.rotation(rotation), .bpp_sel(bpp_sel));

// *** verification/rwa_tb_top.sv ***
// Purpose: Self-checking bench for the window addressing top.
// Assumes: ce high except in its own test; scan positions in position units.
// Notes: Walk directions per rotation follow the designer's choices.
`timescale 1ns/1ps

// ********
// Bench
// ********
module rwa_tb_top;
	reg clock = 1'b0;
	reg rstn = 1'b0;
	reg ce = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h00000000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg frame_start = 1'b0;
	reg line_start = 1'b0;
	reg fetch = 1'b0;
	reg [9:0] scan_x = 10'h000;
	reg [9:0] scan_y = 10'h000;
	wire [31:0] reg_rdata;
	wire [16:0] fetch_addr;
	wire fetch_ovl;
	wire fetch_valid;
	wire [14:0] virt_width;
	wire [1:0] rotation;
	wire [4:0] bpp_sel;
	integer failures = 0;
	integer checks = 0;
	integer cycles = 0;
	integer i;
	reg [16:0] s;
	reg [16:0] dp;
	reg [16:0] dl;
	localparam logic [7:0] tab_addr [0:7] = '{8'h10, 8'h40, 8'h44, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h20};
	localparam logic [31:0] tab_mask [0:7] = '{32'h03DB001F, 32'h0001FFFF, 32'h000003FF,
		32'h0001FFFF, 32'h000003FF, 32'h03FF03FF, 32'h03FF03FF, 32'h00000000};
	// Main window of a 320x240 panel at 4 bpp from byte zero, by the software formulas.
	localparam [31:0] main_180 = (32'hA0 * 32'hEF + 32'hA0 + ((32'h4 - 32'hA0) & 32'h3)) / 32'h4 - 32'h1;
	localparam [31:0] main_270 = (32'h13F * 32'h78) / 32'h4;
	// Overlay 16x4 pixels at 4 bpp: 8-byte lines placed from byte 2000h.
	localparam [31:0] ovl_b = 32'h2000;
	localparam [31:0] ovl_w = 32'h8;
	localparam [31:0] ovl_pad = (32'h4 - ovl_w) & 32'h3;

	rwa_top rwa_top_inst (.clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .line_start(line_start), .fetch(fetch), .scan_x(scan_x),
		.scan_y(scan_y), .fetch_addr(fetch_addr), .fetch_ovl(fetch_ovl),
		.fetch_valid(fetch_valid), .virt_width(virt_width), .rotation(rotation),
		.bpp_sel(bpp_sel));

	// Clock of 8 ns period.
	always #4 clock = ~clock;

	// Cut a hang short; the whole run needs well under a thousand cycles.
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			failures = failures + 1;
			summarize;
		end
	end

	task cmp(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clock);
			reg_wr <= 1'b0;
		end
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task rd(input [7:0] a, input [31:0] exp);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clock);
			reg_rd <= 1'b0;
			#1;
			cmp(reg_rdata, exp);
		end
	endtask

	task strobe(input fs, input ls);
		begin
			@(posedge clock);
			frame_start <= fs;
			line_start <= ls;
			@(posedge clock);
			frame_start <= 1'b0;
			line_start <= 1'b0;
		end
	endtask

	// Scan settles two edges before the fetch, so the hit decode is steady.
	task fet(input [9:0] x, input [9:0] y, input [16:0] ea, input eo);
		begin
			@(posedge clock);
			scan_x <= x;
			scan_y <= y;
			repeat (2) @(posedge clock);
			fetch <= 1'b1;
			@(posedge clock);
			fetch <= 1'b0;
			#1;
			cmp({31'h0, fetch_valid}, 32'h00000001);
			cmp({15'h0, fetch_addr}, {15'h0, ea});
			cmp({31'h0, fetch_ovl}, {31'h0, eo});
		end
	endtask

	// Overlay start for one rotation, seen as the first overlay fetch of a frame.
	task ovl_try(input [1:0] r, input [31:0] a);
		begin
			wr(8'h50, a);
			wr(8'h10, {12'h000, 1'b1, 1'b0, r, 16'h0004});
			strobe(1'b1, 1'b0);
			fet(10'h003, 10'h003, a[16:0], 1'b1);
		end
	endtask

	// Main start and offset for one rotation, then one line step backwards.
	task main_try(input [1:0] r, input [31:0] st, input [31:0] lo);
		begin
			wr(8'h10, {14'h0000, r, 16'h0004});
			wr(8'h40, st);
			wr(8'h44, lo);
			strobe(1'b1, 1'b0);
			fet(10'h000, 10'h000, st[16:0], 1'b0);
			strobe(1'b0, 1'b1);
			fet(10'h000, 10'h000, st[16:0] - lo[16:0], 1'b0);
		end
	endtask

	task summarize;
		begin
			$display("Checks %0d, failures %0d", checks, failures);
			if (failures == 0 && checks > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask

	// Main sequence of tests.
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		cmp({24'h0, rotation, bpp_sel, fetch_valid}, 32'h00000000);
		rd(8'h10, 32'h00000000);
		rd(8'h50, 32'h00000000);
		$display("Test reset done");
		for (i = 0; i < 8; i = i + 1) begin
			wr(tab_addr[i], 32'hFFFFFFFF);
			rd(tab_addr[i], tab_mask[i]);
		end
		wr(8'h40, 32'h00000ABC);
		rd(8'h50, 32'h0001FFFF);
		$display("Test registers done");
		wr(8'h44, 32'h000003FF);
		for (i = 0; i < 5; i = i + 1) begin
			wr(8'h10, 32'h00000001 << i);
			repeat (3) @(posedge clock);
			#1;
			cmp({17'h0, virt_width}, (32'h000003FF * 32) >> i);
		end
		// Odd widths pad up to whole dwords; the spare pixels justify the image.
		wr(8'h10, 32'h00020004);
		wr(8'h44, (32'h64 + 32'h7) / 32'h8);
		repeat (3) @(posedge clock);
		#1;
		cmp({17'h0, virt_width}, 32'h68);
		cmp({17'h0, virt_width} - 32'h64, 32'h4);
		wr(8'h10, 32'h00010004);
		wr(8'h44, (32'h4B + 32'h7) / 32'h8);
		repeat (3) @(posedge clock);
		#1;
		cmp({17'h0, virt_width}, 32'h50);
		cmp({17'h0, virt_width} - 32'h4B, 32'h5);
		$display("Test virtual width done");
		for (i = 0; i < 4; i = i + 1) begin
			s = 17'h01000 * i[16:0];
			dp = (i == 1 || i == 2) ? 17'h1FFFF : 17'h00001;
			dl = (i >= 2) ? 17'h1FFD8 : 17'h00028;
			wr(8'h10, {14'h0, i[1:0], 16'h0004});
			wr(8'h40, {15'h0, s});
			wr(8'h44, 32'h00000028);
			#1;
			cmp({25'h0, rotation, bpp_sel}, {25'h0, i[1:0], 5'h04});
			strobe(1'b1, 1'b0);
			fet(10'h000, 10'h000, s, 1'b0);
			fet(10'h000, 10'h000, s + dp, 1'b0);
			strobe(1'b0, 1'b1);
			fet(10'h000, 10'h000, s + dl, 1'b0);
			@(posedge clock);
			line_start <= 1'b1;
			fetch <= 1'b1;
			@(posedge clock);
			line_start <= 1'b0;
			fetch <= 1'b0;
			#1;
			cmp({31'h0, fetch_valid}, 32'h00000000);
			fet(10'h000, 10'h000, s + dl + dl, 1'b0);
		end
		$display("Test rotated walks done");
		wr(8'h40, 32'h00000100);
		wr(8'h50, 32'h00000800);
		wr(8'h54, 32'h00000008);
		wr(8'h58, 32'h00050002);
		wr(8'h5C, 32'h00030001);
		wr(8'h10, 32'h00080004);
		strobe(1'b1, 1'b0);
		fet(10'h003, 10'h001, 17'h00800, 1'b1);
		fet(10'h007, 10'h001, 17'h00101, 1'b0);
		fet(10'h004, 10'h001, 17'h00801, 1'b1);
		strobe(1'b0, 1'b1);
		fet(10'h002, 10'h002, 17'h00808, 1'b1);
		rd(8'h60, 32'h00010003);
		fet(10'h002, 10'h005, 17'h00129, 1'b0);
		wr(8'h10, 32'h00000004);
		strobe(1'b1, 1'b0);
		fet(10'h003, 10'h001, 17'h00100, 1'b0);
		wr(8'h10, 32'h00090004);
		strobe(1'b1, 1'b0);
		fet(10'h001, 10'h003, 17'h00800, 1'b1);
		fet(10'h003, 10'h001, 17'h000FF, 1'b0);
		$display("Test overlay done");
		ovl_try(2'h0, ovl_b / 32'h4);
		ovl_try(2'h1, (ovl_b + ovl_w + ovl_pad) / 32'h4 - 32'h1);
		ovl_try(2'h2, (ovl_b + ovl_w * 32'h3 + ovl_w + ovl_pad) / 32'h4 - 32'h1);
		ovl_try(2'h3, (ovl_b + 32'h3 * ovl_w) / 32'h4);
		main_try(2'h2, main_180, 32'h28);
		main_try(2'h3, main_270, 32'h1E);
		$display("Test start formulas done");
		// A write while the clock enable is low must leave no trace.
		@(posedge clock);
		ce <= 1'b0;
		wr(8'h40, 32'h00000555);
		ce <= 1'b1;
		rd(8'h40, main_270);
		$display("Test clock enable done");
		summarize;
	end
endmodule
